// ===== serial_dma_pkg.sv
// constants and types shared by the serial dma address register block
package serial_dma_pkg;

  // ************************************************************
  // widths and layout
  // ************************************************************
  localparam int APB_W = 32;
  localparam int HALF_W = 16;
  localparam int BYTE_W = 8;
  localparam int LANES = 2;
  localparam int NUM_CHANNELS = 2;
  localparam int WORD_SHIFT = 2;
  localparam int LOW_BASE_MSB = 15;
  localparam int LOW_BASE_LSB = 11;
  localparam int LOW_OFS_MSB = 10;
  localparam int LOW_OFS_LSB = 1;
  localparam int HIGH_FIELD_MSB = 4;
  localparam int HIGH_FIELD_LSB = 0;
  localparam int HIGH_FIELD_W = 5;
  localparam int UPPER_ZERO_W = 11;
  localparam int WINDOW_BITS = 11;
  localparam logic [HALF_W-1:0] LOW_WRITE_MASK = 16'hfffe;
  localparam logic [HALF_W-1:0] HIGH_WRITE_MASK = 16'h001f;
  localparam logic [APB_W-1:0] DMA_ADDR_MAX = 32'h001ffffe;

  // ************************************************************
  // register indices, byte address is four times the index
  // ************************************************************
  localparam logic [APB_W-1:0] RX_LOW_INDEX = 32'h0b000024;
  localparam logic [APB_W-1:0] RX_HIGH_INDEX = 32'h0b000026;
  localparam logic [APB_W-1:0] TX_LOW_INDEX = 32'h0b000028;
  localparam logic [APB_W-1:0] TX_HIGH_INDEX = 32'h0b00002a;
  localparam logic [HALF_W-1:0] RX_LOW_RESET = 16'hf000;
  localparam logic [HALF_W-1:0] RX_HIGH_RESET = 16'h001f;
  localparam logic [HALF_W-1:0] TX_LOW_RESET = 16'he800;
  localparam logic [HALF_W-1:0] TX_HIGH_RESET = 16'h001f;

  typedef enum {CH_RX, CH_TX} channel_type;

  localparam logic [APB_W-1:0] LOW_INDEX [NUM_CHANNELS] = '{RX_LOW_INDEX, TX_LOW_INDEX};
  localparam logic [APB_W-1:0] HIGH_INDEX [NUM_CHANNELS] = '{RX_HIGH_INDEX, TX_HIGH_INDEX};
  localparam logic [HALF_W-1:0] LOW_RESET [NUM_CHANNELS] = '{RX_LOW_RESET, TX_LOW_RESET};
  localparam logic [HALF_W-1:0] HIGH_RESET [NUM_CHANNELS] = '{RX_HIGH_RESET, TX_HIGH_RESET};

  // index to byte address on the apb side
  function automatic logic [APB_W-1:0] index_to_byte(input logic [APB_W-1:0] idx);
    return APB_W'(idx << WORD_SHIFT);
  endfunction : index_to_byte

endpackage : serial_dma_pkg

// ===== chan_reg_if.sv
// carrier between the register front end and one channel's address registers
`timescale 1ns/1ns
interface chan_reg_if;
  logic wr_low;
  logic wr_high;
  logic [serial_dma_pkg::HALF_W-1:0] wdata;
  logic [serial_dma_pkg::LANES-1:0] strb;
  logic [serial_dma_pkg::HALF_W-1:0] low_q;
  logic [serial_dma_pkg::HALF_W-1:0] high_q;
  logic [serial_dma_pkg::APB_W-1:0] dma_addr;

  modport ctrl (
    output wr_low,
    output wr_high,
    output wdata,
    output strb,
    input low_q,
    input high_q,
    input dma_addr
  );
  modport chan (
    input wr_low,
    input wr_high,
    input wdata,
    input strb,
    output low_q,
    output high_q,
    output dma_addr
  );
endinterface : chan_reg_if

// ===== apb_wait_state.sv
// apb access phase timing: one wait state, then pready for one cycle
`timescale 1ns/1ns
module apb_wait_state (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  output logic pready
);

  typedef enum {PHASE_IDLE, PHASE_ANSWER} phase_type;

  phase_type phase_reg;
  logic pready_reg;

  // answer on the second access cycle so read data can come from a flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_reg <= PHASE_IDLE;
      pready_reg <= 1'b0;
    end else begin
      unique case (phase_reg)
        PHASE_IDLE: begin
          if (psel && penable) begin
            phase_reg <= PHASE_ANSWER;
            pready_reg <= 1'b1;
          end
        end
        PHASE_ANSWER: begin
          phase_reg <= PHASE_IDLE;
          pready_reg <= 1'b0;
        end
      endcase
    end
  end

  assign pready = pready_reg;

endmodule : apb_wait_state

// ===== chan_addr_regs.sv
// one dma channel: low and high address registers and the consumer address
`timescale 1ns/1ns
module chan_addr_regs #(
  parameter logic [15:0] LOW_INIT = 16'h0000,
  parameter logic [15:0] HIGH_INIT = 16'h0000
) (
  input wire logic clk,
  input wire logic rst,
  chan_reg_if.chan bus
);

  logic [serial_dma_pkg::HALF_W-1:0] low_reg;
  logic [serial_dma_pkg::HALF_W-1:0] low_next;
  logic [serial_dma_pkg::HALF_W-1:0] high_reg;
  logic [serial_dma_pkg::HALF_W-1:0] high_next;
  logic [serial_dma_pkg::APB_W-1:0] addr_reg;

  // byte-lane merge; masks keep bit 0 and the upper high bits at zero
  always_comb begin
    low_next = low_reg;
    high_next = high_reg;
    for (int b = 0; b < serial_dma_pkg::LANES; b++) begin
      if (bus.wr_low && bus.strb[b]) begin
        low_next[b*serial_dma_pkg::BYTE_W +: serial_dma_pkg::BYTE_W] =
          bus.wdata[b*serial_dma_pkg::BYTE_W +: serial_dma_pkg::BYTE_W];
      end
      if (bus.wr_high && bus.strb[b]) begin
        high_next[b*serial_dma_pkg::BYTE_W +: serial_dma_pkg::BYTE_W] =
          bus.wdata[b*serial_dma_pkg::BYTE_W +: serial_dma_pkg::BYTE_W];
      end
    end
    low_next = low_next & serial_dma_pkg::LOW_WRITE_MASK;
    high_next = high_next & serial_dma_pkg::HIGH_WRITE_MASK;
  end

  // register storage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_reg <= LOW_INIT & serial_dma_pkg::LOW_WRITE_MASK;
      high_reg <= HIGH_INIT & serial_dma_pkg::HIGH_WRITE_MASK;
    end else begin
      low_reg <= low_next;
      high_reg <= high_next;
    end
  end

  // consumer address follows the registers in the same cycle, top bits forced low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_reg <= {{serial_dma_pkg::UPPER_ZERO_W{1'b0}},
                   HIGH_INIT[serial_dma_pkg::HIGH_FIELD_MSB:serial_dma_pkg::HIGH_FIELD_LSB],
                   LOW_INIT & serial_dma_pkg::LOW_WRITE_MASK};
    end else begin
      addr_reg <= {{serial_dma_pkg::UPPER_ZERO_W{1'b0}},
                   high_next[serial_dma_pkg::HIGH_FIELD_MSB:serial_dma_pkg::HIGH_FIELD_LSB],
                   low_next};
    end
  end

  assign bus.low_q = low_reg;
  assign bus.high_q = high_reg;
  assign bus.dma_addr = addr_reg;

endmodule : chan_addr_regs

// ===== serial_dma_addr_regs.sv
// apb register block holding the serial receive and transmit dma addresses
`timescale 1ns/1ns
module serial_dma_addr_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] rx_dma_addr,
  output logic [31:0] tx_dma_addr
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic pready_w;
  logic commit;
  logic capture;
  logic [serial_dma_pkg::APB_W-1:0] prdata_reg;
  logic [serial_dma_pkg::APB_W-1:0] rdata_next;
  logic pslverr_reg;
  logic miss_next;
  logic [serial_dma_pkg::HALF_W-1:0] low_q_arr [serial_dma_pkg::NUM_CHANNELS];
  logic [serial_dma_pkg::HALF_W-1:0] high_q_arr [serial_dma_pkg::NUM_CHANNELS];
  logic [serial_dma_pkg::APB_W-1:0] dma_addr_arr [serial_dma_pkg::NUM_CHANNELS];

  chan_reg_if ch_if [serial_dma_pkg::NUM_CHANNELS] ();

  // full-address compare; misaligned or foreign addresses never hit
  function automatic logic reg_hit(
    input logic [serial_dma_pkg::APB_W-1:0] addr,
    input logic [serial_dma_pkg::APB_W-1:0] index
  );
    return addr == serial_dma_pkg::index_to_byte(index);
  endfunction : reg_hit

  // ************************************************************
  // apb handshake
  // ************************************************************
  apb_wait_state u_wait (
    .clk(clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pready(pready_w)
  );

  // writes land only at the edge where the master sees pready
  assign commit = psel && penable && pready_w;
  // read data and error are loaded on the wait cycle, ready with pready
  assign capture = psel && penable && !pready_w;

  // ************************************************************
  // channels
  // ************************************************************
  generate
    for (genvar g = 0; g < serial_dma_pkg::NUM_CHANNELS; g++) begin : g_chan
      // strobes decoded per channel, only the low two byte lanes matter
      assign ch_if[g].wr_low = commit && pwrite
        && reg_hit(paddr, serial_dma_pkg::LOW_INDEX[g]);
      assign ch_if[g].wr_high = commit && pwrite
        && reg_hit(paddr, serial_dma_pkg::HIGH_INDEX[g]);
      assign ch_if[g].wdata = pwdata[serial_dma_pkg::HALF_W-1:0];
      assign ch_if[g].strb = pstrb[serial_dma_pkg::LANES-1:0];
      assign low_q_arr[g] = ch_if[g].low_q;
      assign high_q_arr[g] = ch_if[g].high_q;
      assign dma_addr_arr[g] = ch_if[g].dma_addr;

      chan_addr_regs #(
        .LOW_INIT(serial_dma_pkg::LOW_RESET[g]),
        .HIGH_INIT(serial_dma_pkg::HIGH_RESET[g])
      ) u_chan (
        .clk(clk),
        .rst(rst),
        .bus(ch_if[g])
      );
    end
  endgenerate

  // ************************************************************
  // read path
  // ************************************************************
  // read mux, narrow registers sit in the low half with zeros above
  always_comb begin
    rdata_next = '0;
    miss_next = 1'b1;
    for (int c = 0; c < serial_dma_pkg::NUM_CHANNELS; c++) begin
      if (reg_hit(paddr, serial_dma_pkg::LOW_INDEX[c])) begin
        rdata_next = {{serial_dma_pkg::HALF_W{1'b0}}, low_q_arr[c]};
        miss_next = 1'b0;
      end
      if (reg_hit(paddr, serial_dma_pkg::HIGH_INDEX[c])) begin
        rdata_next = {{serial_dma_pkg::HALF_W{1'b0}}, high_q_arr[c]};
        miss_next = 1'b0;
      end
    end
  end

  // read data register; writes return zero data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_reg <= '0;
    end else if (capture) begin
      prdata_reg <= pwrite ? '0 : rdata_next;
    end
  end

  // slave error for any unmapped address, cleared once the answer is gone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pslverr_reg <= 1'b0;
    end else if (capture) begin
      pslverr_reg <= miss_next;
    end else begin
      pslverr_reg <= 1'b0;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_w;
  assign pslverr = pslverr_reg;
  // consumer addresses straight from the channel flops
  assign rx_dma_addr = dma_addr_arr[serial_dma_pkg::CH_RX];
  assign tx_dma_addr = dma_addr_arr[serial_dma_pkg::CH_TX];

  // ************************************************************
  // checks
  // ************************************************************
  // low-register write with both lanes keeps bits 15..1 of the data
  property p_rx_low_store;
    @(posedge clk) disable iff (rst)
      (commit && pwrite && pstrb[1:0] == 2'h3
       && reg_hit(paddr, serial_dma_pkg::RX_LOW_INDEX))
      |=> low_q_arr[serial_dma_pkg::CH_RX][15:1] == $past(pwdata[15:1]);
  endproperty
  a_rx_low_store: assert property (p_rx_low_store)
    else $error("rx low register did not store bits 15..1");

  // bit 0 of receive low never reads back as one
  property p_rx_low_bit0;
    @(posedge clk) disable iff (rst)
      (pready && !pwrite && reg_hit(paddr, serial_dma_pkg::RX_LOW_INDEX))
      |-> prdata[0] == 1'b0 && prdata[31:16] == 16'h0000;
  endproperty
  a_rx_low_bit0: assert property (p_rx_low_bit0)
    else $error("rx low register bit 0 read as one");

  // receive high: only bits 4..0 survive a write
  property p_rx_high_store;
    @(posedge clk) disable iff (rst)
      (commit && pwrite && pstrb[1:0] == 2'h3
       && reg_hit(paddr, serial_dma_pkg::RX_HIGH_INDEX))
      |=> high_q_arr[serial_dma_pkg::CH_RX] == {11'h000, $past(pwdata[4:0])};
  endproperty
  a_rx_high_store: assert property (p_rx_high_store)
    else $error("rx high register field wrong after write");

  // transmit low write keeps bits 15..1
  property p_tx_low_store;
    @(posedge clk) disable iff (rst)
      (commit && pwrite && pstrb[1:0] == 2'h3
       && reg_hit(paddr, serial_dma_pkg::TX_LOW_INDEX))
      |=> low_q_arr[serial_dma_pkg::CH_TX][15:1] == $past(pwdata[15:1]);
  endproperty
  a_tx_low_store: assert property (p_tx_low_store)
    else $error("tx low register did not store bits 15..1");

  // transmit low bit 0 stays zero for the four cycles after a write
  property p_tx_low_bit0;
    @(posedge clk) disable iff (rst)
      (commit && pwrite && reg_hit(paddr, serial_dma_pkg::TX_LOW_INDEX))
      |=> (low_q_arr[serial_dma_pkg::CH_TX][0] == 1'b0) [*4];
  endproperty
  a_tx_low_bit0: assert property (p_tx_low_bit0)
    else $error("tx low register bit 0 became one");

  // transmit high read shows zero above bit 4
  property p_tx_high_read;
    @(posedge clk) disable iff (rst)
      (pready && !pwrite && reg_hit(paddr, serial_dma_pkg::TX_HIGH_INDEX))
      |-> prdata[31:5] == 27'h0000000;
  endproperty
  a_tx_high_read: assert property (p_tx_high_read)
    else $error("tx high register upper bits read nonzero");

  // consumer address never leaves the documented range and stays even
  property p_addr_range;
    @(posedge clk) disable iff (rst)
      rx_dma_addr <= serial_dma_pkg::DMA_ADDR_MAX && tx_dma_addr <= serial_dma_pkg::DMA_ADDR_MAX
      && rx_dma_addr[0] == 1'b0 && tx_dma_addr[0] == 1'b0;
  endproperty
  a_addr_range: assert property (p_addr_range)
    else $error("dma address outside the allowed range");

  // transmit address is high field over low field in the same cycle
  property p_addr_concat;
    @(posedge clk) disable iff (rst)
      $changed(low_q_arr[serial_dma_pkg::CH_TX]) || $changed(high_q_arr[serial_dma_pkg::CH_TX])
      |-> tx_dma_addr == {11'h000, high_q_arr[serial_dma_pkg::CH_TX][4:0],
                          low_q_arr[serial_dma_pkg::CH_TX]};
  endproperty
  a_addr_concat: assert property (p_addr_concat)
    else $error("tx dma address does not match its registers");

  // rx address tracks its registers at all times
  property p_rx_concat;
    @(posedge clk) disable iff (rst)
      rx_dma_addr == {11'h000, high_q_arr[serial_dma_pkg::CH_RX][4:0],
                      low_q_arr[serial_dma_pkg::CH_RX]};
  endproperty
  a_rx_concat: assert property (p_rx_concat)
    else $error("rx dma address does not match its registers");

  // one wait state: pready exactly one cycle after the access phase opens
  property p_one_wait;
    @(posedge clk) disable iff (rst)
      (psel && penable && !pready) |=> pready ##1 !pready;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("pready did not follow the access phase by one cycle");

  // transmit high: only bits 4..0 survive a write
  property p_tx_high_store;
    @(posedge clk) disable iff (rst)
      (commit && pwrite && pstrb[1:0] == 2'h3
       && reg_hit(paddr, serial_dma_pkg::TX_HIGH_INDEX))
      |=> high_q_arr[serial_dma_pkg::CH_TX] == {11'h000, $past(pwdata[4:0])};
  endproperty
  a_tx_high_store: assert property (p_tx_high_store)
    else $error("tx high register field wrong after write");

  // an unstrobed lane keeps its byte, so partial writes cannot smear the base
  property p_rx_lane_keep;
    @(posedge clk) disable iff (rst)
      (commit && pwrite && !pstrb[1] && reg_hit(paddr, serial_dma_pkg::RX_LOW_INDEX))
      |=> low_q_arr[serial_dma_pkg::CH_RX][15:8]
          == $past(low_q_arr[serial_dma_pkg::CH_RX][15:8]);
  endproperty
  a_rx_lane_keep: assert property (p_rx_lane_keep)
    else $error("rx low register upper byte changed without its strobe");

  // receive high read shows zero above bit 4
  property p_rx_high_read;
    @(posedge clk) disable iff (rst)
      (pready && !pwrite && reg_hit(paddr, serial_dma_pkg::RX_HIGH_INDEX))
      |-> prdata[31:5] == 27'h0000000;
  endproperty
  a_rx_high_read: assert property (p_rx_high_read)
    else $error("rx high register upper bits read nonzero");

  // transmit low read: bit 0 and the upper half are zero
  property p_tx_low_read;
    @(posedge clk) disable iff (rst)
      (pready && !pwrite && reg_hit(paddr, serial_dma_pkg::TX_LOW_INDEX))
      |-> prdata[0] == 1'b0 && prdata[31:16] == 16'h0000;
  endproperty
  a_tx_low_read: assert property (p_tx_low_read)
    else $error("tx low register bit 0 read as one");

  // receive address picks up a full low write on the next cycle
  property p_rx_addr_follow;
    @(posedge clk) disable iff (rst)
      (commit && pwrite && pstrb[1:0] == 2'h3
       && reg_hit(paddr, serial_dma_pkg::RX_LOW_INDEX))
      |=> rx_dma_addr[15:1] == $past(pwdata[15:1]) && rx_dma_addr[0] == 1'b0;
  endproperty
  a_rx_addr_follow: assert property (p_rx_addr_follow)
    else $error("rx dma address missed a low register write");

  // transmit address picks up a high write in bits 20..16, nothing above
  property p_tx_addr_follow;
    @(posedge clk) disable iff (rst)
      (commit && pwrite && pstrb[1:0] == 2'h3
       && reg_hit(paddr, serial_dma_pkg::TX_HIGH_INDEX))
      |=> tx_dma_addr[20:16] == $past(pwdata[4:0]) && tx_dma_addr[31:21] == 11'h000;
  endproperty
  a_tx_addr_follow: assert property (p_tx_addr_follow)
    else $error("tx dma address missed a high register write");

  // write answers carry zero data so stale read data never leaks out
  property p_write_zero;
    @(posedge clk) disable iff (rst)
      (pready && pwrite) |-> prdata == 32'h00000000;
  endproperty
  a_write_zero: assert property (p_write_zero)
    else $error("write answer carried nonzero read data");

  // an error answer only ever comes together with ready
  property p_err_with_ready;
    @(posedge clk) disable iff (rst)
      pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("slave error raised outside the ready cycle");

endmodule : serial_dma_addr_regs

// ===== serial_consumer_model.sv
// consumer model: serial unit side that turns channel addresses into dma windows
`timescale 1ns/1ns
module serial_consumer_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] rx_dma_addr,
  input wire logic [31:0] tx_dma_addr,
  output logic [31:0] rx_window,
  output logic [31:0] tx_window,
  output logic rx_in_range,
  output logic tx_in_range
);
  // ************************************************************
  // window arithmetic
  // ************************************************************
  // combinational, so a bench compare sees the window of the current address
  always_comb begin
    rx_window = {rx_dma_addr[31:11], 11'h000};
    tx_window = {tx_dma_addr[31:11], 11'h000};
  end

  // start must be a half-word inside the reachable range, top bits zero
  always_comb begin
    rx_in_range = (rx_dma_addr <= 32'h001ffffe) && (rx_dma_addr[0] == 1'b0);
    tx_in_range = (tx_dma_addr <= 32'h001ffffe) && (tx_dma_addr[0] == 1'b0);
  end
endmodule : serial_consumer_model

// ===== test_serial_dma_addr_regs.sv
// self-checking apb bench for the serial dma address register block
`timescale 1ns/1ns
module test_serial_dma_addr_regs;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h00000000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic [31:0] rx_dma_addr;
  logic [31:0] tx_dma_addr;
  logic [31:0] rx_window;
  logic [31:0] tx_window;
  logic pready;
  logic pslverr;
  logic rx_in_range;
  logic tx_in_range;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int checks = 0;
  // byte address is four times the register index
  localparam logic [31:0] A_RXL = {serial_dma_pkg::RX_LOW_INDEX[29:0], 2'b00};
  localparam logic [31:0] A_RXH = {serial_dma_pkg::RX_HIGH_INDEX[29:0], 2'b00};
  localparam logic [31:0] A_TXL = {serial_dma_pkg::TX_LOW_INDEX[29:0], 2'b00};
  localparam logic [31:0] A_TXH = {serial_dma_pkg::TX_HIGH_INDEX[29:0], 2'b00};
  localparam logic [31:0] ADDRS [4] = '{A_RXL, A_RXH, A_TXL, A_TXH};

  always #10 clk = ~clk;

  serial_dma_addr_regs dut_u (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_dma_addr(rx_dma_addr),
    .tx_dma_addr(tx_dma_addr)
  );

  serial_consumer_model far_u (
    .clk(clk), .rst(rst), .rx_dma_addr(rx_dma_addr), .tx_dma_addr(tx_dma_addr),
    .rx_window(rx_window), .tx_window(tx_window),
    .rx_in_range(rx_in_range), .tx_in_range(tx_in_range)
  );

  // ************************************************************
  // comparison and bus tasks
  // ************************************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // setup at entry, so calls chain back to back; idle() releases the bus
  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] data,
                     input logic [3:0] strb);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    pstrb <= strb;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) begin
      miscompares++;
      $display("FAIL pready expected 1 seen %b", pready);
    end
    rd = prdata;
    err = pslverr;
  endtask : apb

  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : idle

  // write, expecting a clean answer with zero read data
  task automatic wr(input logic [31:0] addr, input logic [31:0] data, input logic [3:0] strb);
    apb(1'b1, addr, data, strb);
    chk("write error", 32'h0, {31'h0, err});
    chk("write prdata", 32'h0, rd);
  endtask : wr

  task automatic rdc(input logic [31:0] addr, input logic [31:0] exp, input logic eexp);
    apb(1'b0, addr, 32'h0, 4'h0);
    chk("read error", {31'h0, eexp}, {31'h0, err});
    chk("read data", exp, rd);
  endtask : rdc

  task automatic chk_addr(input logic [31:0] rx, input logic [31:0] tx);
    chk("rx dma address", rx, rx_dma_addr);
    chk("tx dma address", tx, tx_dma_addr);
    chk("rx window", {rx[31:11], 11'h000}, rx_window);
    chk("tx window", {tx[31:11], 11'h000}, tx_window);
    chk("in range", 32'h3, {30'h0, rx_in_range, tx_in_range});
  endtask : chk_addr

  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  // ************************************************************
  // test sequence
  // ************************************************************
  // whole run is about a hundred cycles; generous margin before giving up
  initial begin
    #200000;
    miscompares++;
    conclude();
  end

  initial begin
    logic [31:0] rst_val [4];
    logic [31:0] ones_val [4];
    rst_val = '{32'h0000f000, 32'h0000001f, 32'h0000e800, 32'h0000001f};
    ones_val = '{32'h0000fffe, 32'h0000001f, 32'h0000fffe, 32'h0000001f};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_addr(32'h001ff000, 32'h001fe800);
    for (int i = 0; i < 4; i++) begin
      rdc(ADDRS[i], rst_val[i], 1'b0);
    end
    // all ones, back to back: bit 0 and high bits 15..5 must drop
    for (int i = 0; i < 4; i++) begin
      wr(ADDRS[i], 32'hffffffff, 4'hf);
    end
    for (int i = 0; i < 4; i++) begin
      rdc(ADDRS[i], ones_val[i], 1'b0);
    end
    idle();
    chk_addr(32'h001ffffe, 32'h001ffffe);
    // ordinary physical addresses, odd start bit written on purpose
    wr(A_RXL, 32'h00001235, 4'hf);
    wr(A_RXH, 32'h0000ffe5, 4'hf);
    wr(A_TXL, 32'h0000abcd, 4'hf);
    wr(A_TXH, 32'h0000000a, 4'hf);
    rdc(A_RXL, 32'h00001234, 1'b0);
    rdc(A_RXH, 32'h00000005, 1'b0);
    rdc(A_TXL, 32'h0000abcc, 1'b0);
    rdc(A_TXH, 32'h0000000a, 1'b0);
    idle();
    chk_addr(32'h00051234, 32'h000aabcc);
    // byte lanes: only strobed lanes change
    wr(A_RXL, 32'h00005678, 4'b0001);
    wr(A_TXL, 32'h00009900, 4'b1110);
    rdc(A_RXL, 32'h00001278, 1'b0);
    rdc(A_TXL, 32'h000099cc, 1'b0);
    // unmapped, misaligned and printed-offset addresses are refused
    apb(1'b1, A_RXL + 32'h4, 32'h0000ffff, 4'hf);
    chk("unmapped write error", 32'h1, {31'h0, err});
    apb(1'b1, 32'h0b000024, 32'h00000000, 4'hf);
    chk("offset write error", 32'h1, {31'h0, err});
    rdc(A_RXL + 32'h1, 32'h0, 1'b1);
    rdc(A_RXL, 32'h00001278, 1'b0);
    idle();
    chk_addr(32'h00051278, 32'h000a99cc);
    // reset in mid-run restores the initial addresses
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_addr(32'h001ff000, 32'h001fe800);
    rdc(A_TXL, 32'h0000e800, 1'b0);
    idle();
    conclude();
  end
endmodule : test_serial_dma_addr_regs
